// ### logic/rlb_pkg.sv
// Purpose: shared constants of the reset-exit and bootstrap controller
// Assumes: core clock of 200 MHz, reference clock period of 200 ns
// Notes: every count and address used by more than one file lives here
package rlb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int REF_PERIOD_NS = 200;
  localparam int RESET_DELAY_REF = 144;
  localparam int SCAN_REF = 144;
  // least times round up to whole core cycles
  localparam int DELAY_CYC_DEF =
    (RESET_DELAY_REF * REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCAN_CYC_DEF =
    (SCAN_REF * REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_SLOT_NS = 100;
  localparam int REFRESH_SLOT_CYC =
    (REFRESH_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_SHORT_NS = 50;
  localparam int SETTLE_LONG_NS = 200;
  localparam int SETTLE_SHORT_CYC =
    (SETTLE_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_LONG_CYC =
    (SETTLE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 13;

  ////////////////////////////////////////////////////////////////////////////
  // sequence counts and link protocol
  localparam logic [7:0] CFG_READS = 8'h24;
  localparam logic [7:0] REFRESH_COUNT = 8'h08;
  localparam logic [7:0] CTRL_POKE = 8'h00;
  localparam logic [7:0] CTRL_PEEK = 8'h01;
  localparam int NUM_LINKS = 4;

  ////////////////////////////////////////////////////////////////////////////
  // addresses and configuration word layout
  localparam logic [31:0] ROM_BOOT_ADDR = 32'h7ffffffe;
  localparam logic [31:0] USER_MEMORY_BASE = 32'h80000070;
  localparam logic [31:0] CFG_ROM_ADDR = 32'h7fffff6c;
  localparam int CFG_FOUND_BIT = 0;
  localparam int CFG_REFRESH_BIT = 1;
  localparam int CFG_SLOW_BIT = 2;

  ////////////////////////////////////////////////////////////////////////////
  // core rate strap codes, rate in tenths of a megahertz
  localparam logic [2:0] RATE_C20 = 3'h0;
  localparam logic [2:0] RATE_C22 = 3'h1;
  localparam logic [2:0] RATE_C25 = 3'h2;
  localparam logic [2:0] RATE_C30 = 3'h3;
  localparam logic [2:0] RATE_C35 = 3'h4;
  localparam logic [2:0] RATE_C17 = 3'h6;
  localparam logic [9:0] MHZ_20 = 10'h0c8;
  localparam logic [9:0] MHZ_22 = 10'h0e1;
  localparam logic [9:0] MHZ_25 = 10'h0fa;
  localparam logic [9:0] MHZ_30 = 10'h12c;
  localparam logic [9:0] MHZ_35 = 10'h15e;
  localparam logic [9:0] MHZ_17 = 10'h0af;

  typedef enum {
    ST_RESET, ST_DELAY, ST_SCAN, ST_CFGRD, ST_SETTLE, ST_REFRESH,
    ST_DECIDE, ST_CTRL, ST_ADDR, ST_DATA, ST_POKE, ST_PEEK_RD,
    ST_PEEK_TX, ST_LOAD_RX, ST_LOAD_WR, ST_BOOT, ST_RUN
  } rlb_state_t;

endpackage : rlb_pkg

// ### logic/rlb_rate_decode.sv
// Purpose: decode the three core rate strap pins
// Assumes: code is already synchronised
// Notes: invalid codes give a rate of zero and raise the invalid flag
`timescale 1ns/1ps
module rlb_rate_decode (
  input wire logic [2:0] code,
  output logic [9:0] mhz_x10,
  output logic invalid
);
  import rlb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // table lookup, highest pin is the top bit of the code
  function automatic logic [9:0] rate_of(input logic [2:0] c);
    unique case (c)
      RATE_C20: rate_of = MHZ_20;
      RATE_C22: rate_of = MHZ_22;
      RATE_C25: rate_of = MHZ_25;
      RATE_C30: rate_of = MHZ_30;
      RATE_C35: rate_of = MHZ_35;
      RATE_C17: rate_of = MHZ_17;
      default: rate_of = 10'h000;
    endcase
  endfunction : rate_of

  // 101 and 111 are the only codes with no rate
  assign mhz_x10 = rate_of(code);
  assign invalid = (rate_of(code) == 10'h000);

endmodule : rlb_rate_decode

// ### logic/rlb_boot_ctrl.sv
// Purpose: reset-exit sequence, boot choice and link peek/poke loader
// Assumes: links and memory are byte/word handshakes on the core clock
// Notes: reset_pin, straps and boot select are pins and are synchronised
`timescale 1ns/1ps
module rlb_boot_ctrl #(
  parameter int DELAY_CYC = rlb_pkg::DELAY_CYC_DEF,
  parameter int SCAN_CYC = rlb_pkg::SCAN_CYC_DEF
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic reset_pin,
  input wire logic [2:0] core_rate_strap_pins,
  input wire logic rom_boot_select,
  input wire logic config_scan_pin_a,
  input wire logic config_scan_pin_b,
  input wire logic [29:0] config_scan_bus,
  input wire logic [rlb_pkg::NUM_LINKS-1:0] link_rx_valid,
  input wire logic [8*rlb_pkg::NUM_LINKS-1:0] link_rx_data,
  output logic [rlb_pkg::NUM_LINKS-1:0] link_rx_ready,
  output logic [rlb_pkg::NUM_LINKS-1:0] link_tx_valid,
  output logic [8*rlb_pkg::NUM_LINKS-1:0] link_tx_data,
  input wire logic [rlb_pkg::NUM_LINKS-1:0] link_tx_ready,
  output logic mem_req,
  output logic mem_we,
  output logic mem_cfg,
  output logic [31:0] mem_addr,
  output logic [3:0] mem_be,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  output logic refresh_req,
  output logic [9:0] core_rate_mhz_x10,
  output logic core_rate_invalid,
  output logic seq_busy,
  output logic boot_start,
  output logic boot_from_rom,
  output logic boot_low_pri,
  output logic [1:0] boot_link,
  output logic [31:0] boot_iptr,
  output logic [31:0] boot_wptr
);
  import rlb_pkg::*;

  localparam int NL = NUM_LINKS;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: only the second stage is read by logic
  logic [36:0] pin_s1_reg, pin_s2_reg;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_s1_reg <= 37'h0000000001;
      pin_s2_reg <= 37'h0000000001;
    end else begin
      pin_s1_reg <= {config_scan_bus, config_scan_pin_b, config_scan_pin_a,
                     rom_boot_select, core_rate_strap_pins, reset_pin};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  wire rst_s = pin_s2_reg[0];
  wire [2:0] strap_s = pin_s2_reg[3:1];
  wire rom_sel_s = pin_s2_reg[4];
  // scan pins a, b and the bus form one configuration word, a at bit 0
  wire [31:0] scan_pins = pin_s2_reg[36:5];

  ////////////////////////////////////////////////////////////////////////////
  // core rate decode, registered so the outputs come from flops
  wire [9:0] rate_w;
  wire rate_bad_w;
  rlb_rate_decode i_rlb_rate_decode (
    .code(strap_s),
    .mhz_x10(rate_w),
    .invalid(rate_bad_w)
  );
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      core_rate_mhz_x10 <= 10'h000;
      core_rate_invalid <= 1'b0;
    end else begin
      core_rate_mhz_x10 <= rate_w;
      core_rate_invalid <= rate_bad_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and working registers
  rlb_state_t state_reg, state_next;
  logic [TMR_W-1:0] tmr_reg, tmr_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [7:0] len_reg, len_next;
  logic [31:0] word_reg, word_next;
  logic [31:0] addr_reg, addr_next;
  logic [31:0] cfg_reg, cfg_next;
  logic poke_reg, poke_next;
  logic [1:0] sel_reg, sel_next;
  logic rom_sampled_reg, rom_sampled_next;
  logic hold_valid_reg;
  logic [7:0] hold_data_reg;
  logic [1:0] hold_link_reg;

  // first link, lowest index wins, with a byte ready to be taken
  function automatic logic [1:0] first_link(input logic [NL-1:0] v);
    first_link = 2'h0;
    for (int i = NL - 1; i >= 0; i--) begin
      if (v[i]) first_link = 2'(i);
    end
  endfunction : first_link

  // states that own a memory request
  function automatic logic is_mem_state(input rlb_state_t s);
    is_mem_state = (s == ST_CFGRD) || (s == ST_POKE) ||
                   (s == ST_PEEK_RD) || (s == ST_LOAD_WR);
  endfunction : is_mem_state

  ////////////////////////////////////////////////////////////////////////////
  // link receive side: one holding byte for all links
  wire any_link = (state_reg inside {ST_RESET, ST_DELAY, ST_SCAN, ST_CFGRD,
                   ST_SETTLE, ST_REFRESH, ST_DECIDE, ST_CTRL});
  wire own_link = (state_reg inside {ST_ADDR, ST_DATA, ST_LOAD_RX});
  wire [NL-1:0] rx_take = link_rx_valid & link_rx_ready;
  wire take_now = |rx_take;
  wire [1:0] take_link = first_link(rx_take);
  wire need_byte = (state_reg inside {ST_CTRL, ST_ADDR, ST_DATA, ST_LOAD_RX});
  wire consume = need_byte && hold_valid_reg;
  wire [31:0] shifted = {hold_data_reg, word_reg[31:8]};
  wire [NL-1:0] sel_dec = NL'(1) << sel_reg;
  wire [NL-1:0] ready_next = (rst_s || hold_valid_reg || take_now) ?
    {NL{1'b0}} : (any_link ? {NL{1'b1}} : (own_link ? sel_dec : {NL{1'b0}}));

  // a taken byte waits here; ready stays low so later bytes stay at source
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hold_valid_reg <= 1'b0;
      hold_data_reg <= 8'h00;
      hold_link_reg <= 2'h0;
      link_rx_ready <= '0;
    end else begin
      link_rx_ready <= ready_next;
      if (rst_s) begin
        hold_valid_reg <= 1'b0;
      end else if (take_now) begin
        hold_valid_reg <= 1'b1;
        hold_data_reg <= link_rx_data[8*take_link +: 8];
        hold_link_reg <= take_link;
      end else if (consume) begin
        hold_valid_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequence timing decodes
  wire delay_done = (tmr_reg == TMR_W'(DELAY_CYC - 1));
  wire scan_done = (tmr_reg == TMR_W'(SCAN_CYC - 1));
  wire [TMR_W-1:0] settle_last = cfg_reg[CFG_SLOW_BIT] ?
    TMR_W'(SETTLE_LONG_CYC - 1) : TMR_W'(SETTLE_SHORT_CYC - 1);
  wire slot_done = (tmr_reg == TMR_W'(REFRESH_SLOT_CYC - 1));
  wire mem_done = mem_req && mem_ack;
  wire [NL-1:0] tx_fire = link_tx_valid & link_tx_ready;
  wire [31:0] load_ptr = USER_MEMORY_BASE + {24'h0, cnt_reg};
  wire [31:0] free_ptr = USER_MEMORY_BASE + {24'h0, len_reg} + 32'h3;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: reset pin high always returns to the reset state
  always_comb begin
    state_next = state_reg;
    tmr_next = tmr_reg + TMR_W'(1);
    cnt_next = cnt_reg;
    len_next = len_reg;
    word_next = word_reg;
    addr_next = addr_reg;
    cfg_next = cfg_reg;
    poke_next = poke_reg;
    sel_next = sel_reg;
    rom_sampled_next = rom_sampled_reg;
    unique case (state_reg)
      ST_RESET: begin
        tmr_next = '0;
        rom_sampled_next = 1'b0;
        cfg_next = 32'h0; // a new run never reuses an old scan result
        if (!rst_s) state_next = ST_DELAY;
      end
      ST_DELAY: if (delay_done) begin
        state_next = ST_SCAN;
        tmr_next = '0;
      end
      ST_SCAN: begin
        if (pin_s2_reg[5]) cfg_next = scan_pins | 32'h1;
        if (scan_done) begin
          state_next = ST_CFGRD;
          cnt_next = 8'h00;
        end
      end
      ST_CFGRD: if (mem_done) begin
        cnt_next = cnt_reg + 8'h01;
        if (!cfg_reg[CFG_FOUND_BIT]) cfg_next = mem_rdata & 32'hfffffffe;
        if (cnt_reg == CFG_READS - 8'h01) begin
          state_next = ST_SETTLE;
          tmr_next = '0;
        end
      end
      ST_SETTLE: if (tmr_reg == settle_last) begin
        state_next = ST_REFRESH;
        tmr_next = '0;
        cnt_next = 8'h00;
      end
      ST_REFRESH: if (slot_done) begin
        tmr_next = '0;
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == REFRESH_COUNT - 8'h01) state_next = ST_DECIDE;
      end
      ST_DECIDE: begin
        rom_sampled_next = 1'b1;
        state_next = rom_sel_s ? ST_BOOT : ST_CTRL;
      end
      ST_CTRL: if (consume) begin
        sel_next = hold_link_reg;
        cnt_next = 8'h00;
        poke_next = (hold_data_reg == CTRL_POKE);
        len_next = hold_data_reg;
        if (hold_data_reg == CTRL_POKE || hold_data_reg == CTRL_PEEK) begin
          state_next = ST_ADDR;
        end else begin
          state_next = ST_LOAD_RX;
        end
      end
      ST_ADDR: if (consume) begin
        word_next = shifted;
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == 8'h03) begin
          addr_next = shifted;
          cnt_next = 8'h00;
          state_next = poke_reg ? ST_DATA : ST_PEEK_RD;
        end
      end
      ST_DATA: if (consume) begin
        word_next = shifted;
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == 8'h03) state_next = ST_POKE;
      end
      ST_POKE: if (mem_done) state_next = ST_CTRL;
      ST_PEEK_RD: if (mem_done) begin
        word_next = mem_rdata;
        cnt_next = 8'h00;
        state_next = ST_PEEK_TX;
      end
      ST_PEEK_TX: if (|tx_fire) begin
        word_next = {8'h00, word_reg[31:8]};
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == 8'h03) state_next = ST_CTRL;
      end
      ST_LOAD_RX: if (consume) begin
        word_next = {24'h0, hold_data_reg};
        state_next = ST_LOAD_WR;
      end
      ST_LOAD_WR: if (mem_done) begin
        cnt_next = cnt_reg + 8'h01;
        state_next = (cnt_reg == len_reg - 8'h01) ? ST_BOOT : ST_LOAD_RX;
      end
      ST_BOOT: state_next = ST_RUN;
      ST_RUN: state_next = ST_RUN;
    endcase
    if (rst_s) state_next = ST_RESET;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_RESET;
      tmr_reg <= '0;
      cnt_reg <= 8'h00;
      len_reg <= 8'h00;
      word_reg <= 32'h0;
      addr_reg <= 32'h0;
      cfg_reg <= 32'h0;
      poke_reg <= 1'b0;
      sel_reg <= 2'h0;
      rom_sampled_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      cnt_reg <= cnt_next;
      len_reg <= len_next;
      word_reg <= word_next;
      addr_reg <= addr_next;
      cfg_reg <= cfg_next;
      poke_reg <= poke_next;
      sel_reg <= sel_next;
      rom_sampled_reg <= rom_sampled_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory request: held until acknowledged, one idle cycle between
  wire mem_on = is_mem_state(state_next) && !mem_done;
  wire [3:0] byte_be = 4'h1 << load_ptr[1:0];
  wire [31:0] cfg_addr = CFG_ROM_ADDR + {22'h0, cnt_next, 2'h0};
  wire [31:0] addr_sel = (state_next == ST_CFGRD) ? cfg_addr :
                         (state_next == ST_LOAD_WR) ? load_ptr : addr_next;
  wire we_sel = (state_next == ST_POKE) || (state_next == ST_LOAD_WR);
  // bytes go to the lane of their address, so memory stays little-endian
  wire [3:0] be_sel = (state_next == ST_LOAD_WR) ? byte_be : 4'hf;
  wire [31:0] wd_sel = (state_next == ST_LOAD_WR) ?
                       {4{word_next[7:0]}} : word_next;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_cfg <= 1'b0;
      mem_addr <= 32'h0;
      mem_be <= 4'h0;
      mem_wdata <= 32'h0;
    end else begin
      mem_req <= mem_on;
      mem_we <= mem_on && we_sel;
      mem_cfg <= mem_on && (state_next == ST_CFGRD);
      mem_addr <= addr_sel;
      mem_be <= be_sel;
      mem_wdata <= wd_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // refresh pulse at the start of each slot, only if the config allows it
  wire refresh_on = (state_next == ST_REFRESH) && (tmr_next == '0) &&
                    cfg_next[CFG_REFRESH_BIT];
  // link transmit: peek word goes out low byte first on the control link
  wire [NL-1:0] tx_v = (state_next == ST_PEEK_TX) && !rst_s ?
                       NL'(1) << sel_next : {NL{1'b0}};
  wire [8*NL-1:0] tx_d = {NL{word_next[7:0]}};
  genvar g;
  generate
    for (g = 0; g < NL; g++) begin : g_tx
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          link_tx_valid[g] <= 1'b0;
          link_tx_data[8*g +: 8] <= 8'h00;
        end else begin
          link_tx_valid[g] <= tx_v[g];
          link_tx_data[8*g +: 8] <= tx_v[g] ? tx_d[8*g +: 8] : 8'h00;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // boot hand-off to the processor core
  wire boot_now = (state_next == ST_BOOT);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      refresh_req <= 1'b0;
      seq_busy <= 1'b0;
      boot_start <= 1'b0;
      boot_from_rom <= 1'b0;
      boot_low_pri <= 1'b0;
      boot_link <= 2'h0;
      boot_iptr <= 32'h0;
      boot_wptr <= 32'h0;
    end else begin
      refresh_req <= refresh_on;
      seq_busy <= (state_next inside {ST_DELAY, ST_SCAN, ST_CFGRD,
                   ST_SETTLE, ST_REFRESH});
      boot_start <= boot_now;
      if (state_reg == ST_DECIDE) boot_from_rom <= rom_sel_s;
      if (boot_now) begin
        boot_low_pri <= 1'b1;
        boot_link <= sel_reg;
        boot_iptr <= boot_from_rom || (state_reg == ST_DECIDE && rom_sel_s)
                     ? ROM_BOOT_ADDR : USER_MEMORY_BASE;
        boot_wptr <= (state_reg == ST_DECIDE)
                     ? USER_MEMORY_BASE : {free_ptr[31:2], 2'h0};
      end
      if (rst_s) boot_low_pri <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_rate_17;
    $past(strap_s) == RATE_C17 |-> core_rate_mhz_x10 == MHZ_17;
  endproperty
  a_rate_17: assert property (p_rate_17)
    else $error("strap 110 not decoded as 17.5 MHz");

  property p_tx_low;
    $past(rst_s) |-> link_tx_valid == '0 && link_tx_data == '0;
  endproperty
  a_tx_low: assert property (p_tx_low)
    else $error("link output active during reset");

  sequence s_release;
    $fell(rst_s) && state_reg == ST_RESET;
  endsequence
  property p_delay_quiet;
    s_release |=> (!mem_req && !refresh_req) [*8];
  endproperty
  a_delay_quiet: assert property (p_delay_quiet)
    else $error("memory activity early in the post-reset delay");

  property p_scan_len;
    $rose(state_reg == ST_CFGRD) |-> $past(tmr_reg) == TMR_W'(SCAN_CYC - 1);
  endproperty
  a_scan_len: assert property (p_scan_len)
    else $error("scan phase did not last its full length");

  property p_cfg_reads;
    $rose(state_reg == ST_SETTLE) |-> $past(cnt_reg) == CFG_READS - 8'h01;
  endproperty
  a_cfg_reads: assert property (p_cfg_reads)
    else $error("wrong number of configuration reads");

  property p_refresh_count;
    $rose(state_reg == ST_DECIDE) |-> $past(cnt_reg) == REFRESH_COUNT - 8'h01;
  endproperty
  a_refresh_count: assert property (p_refresh_count)
    else $error("refresh block not eight slots long");

  property p_no_refresh;
    state_reg == ST_REFRESH && !cfg_reg[CFG_REFRESH_BIT] |->
      !refresh_req && !mem_req;
  endproperty
  a_no_refresh: assert property (p_no_refresh)
    else $error("memory activity while refresh is disabled");

  property p_rom_boot;
    boot_start && boot_from_rom |->
      boot_iptr == ROM_BOOT_ADDR && boot_wptr == USER_MEMORY_BASE;
  endproperty
  a_rom_boot: assert property (p_rom_boot)
    else $error("ROM boot pointers wrong");

  property p_rom_once;
    rom_sampled_reg && state_reg != ST_DECIDE |=> $stable(boot_from_rom);
  endproperty
  a_rom_once: assert property (p_rom_once)
    else $error("boot select resampled");

  property p_first_ready;
    s_release ##0 !hold_valid_reg ##1 !take_now |=> &link_rx_ready;
  endproperty
  a_first_ready: assert property (p_first_ready)
    else $error("links not ready soon after reset");

  property p_poke_write;
    state_reg == ST_POKE && mem_req |-> mem_we && mem_be == 4'hf &&
      mem_addr == addr_reg && mem_wdata == word_reg;
  endproperty
  a_poke_write: assert property (p_poke_write)
    else $error("poke write does not carry address and word");

endmodule : rlb_boot_ctrl

// ### test/rlb_mem_model.sv
// Purpose: memory partner of the bootstrap controller
// Assumes: configuration reads return CFG_WORD
// Notes: latency varies with address; idle read data toggles
`timescale 1ns/1ps
module rlb_mem_model #(
  parameter logic [31:0] CFG_WORD = 32'h00000003
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_cfg,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0] mem_be,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  logic [31:0] mem [logic [31:0]];
  logic [1:0] wait_reg;
  // one ack per request; stale data never looks valid
  always @(posedge clock or negedge rstn) begin
    logic [31:0] a, w;
    if (!rstn) begin
      mem_ack <= 1'b0;
      wait_reg <= 2'h0;
      mem_rdata <= 32'h0;
    end else begin
      a = {mem_addr[31:2], 2'h0};
      w = mem.exists(a) ? mem[a] : 32'h0;
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack && wait_reg != 2'h0) begin
        wait_reg <= wait_reg - 2'h1;
      end else if (mem_req && !mem_ack) begin
        mem_ack <= 1'b1;
        wait_reg <= mem_addr[3:2];
        mem_rdata <= mem_cfg ? CFG_WORD : w;
        // only enabled lanes change, so bytes keep their place in the word
        for (int i = 0; i < 4; i++) begin
          if (mem_be[i]) w[8*i+:8] = mem_wdata[8*i+:8];
        end
        if (mem_we) mem[a] = w;
      end
    end
  end
endmodule : rlb_mem_model

// ### test/rlb_boot_ctrl_test.sv
// Purpose: self-checking bench of the bootstrap controller
// Assumes: short delay and scan counts, refresh enabled by config
// Notes: link replies are stalled by a seeded random ready
`timescale 1ns/1ps
module rlb_boot_ctrl_test;
  import rlb_pkg::*;
  logic clock = 0, rstn = 0, reset_pin = 1, rom_sel = 0, lowp, bst;
  logic scan_a = 0, brom, busy;
  logic [2:0] straps = 0;
  logic [3:0] rxv = 0, rxr, txv, txr = 0, be;
  logic [31:0] rxd = 0, txd, rd, ma, wd, iptr, adr, dat, wptr;
  logic req, we, cfg, ack, rfr, inval;
  logic [9:0] mhz;
  logic [1:0] blink;
  logic [7:0] exp_q[$];
  int num_errors = 0, total_checks = 0, seed = 46661, n_ref = 0, n_cfg = 0;
  logic [9:0] tab[8] = '{MHZ_20, MHZ_22, MHZ_25, MHZ_30, MHZ_35, 10'h0,
                         MHZ_17, 10'h0};
  rlb_boot_ctrl #(.DELAY_CYC(20), .SCAN_CYC(20)) i_rlb_boot_ctrl (
    .clock(clock), .rstn(rstn), .reset_pin(reset_pin),
    .core_rate_strap_pins(straps), .rom_boot_select(rom_sel),
    .config_scan_pin_a(scan_a), .config_scan_pin_b(1'b0),
    .config_scan_bus(30'h0), .link_rx_valid(rxv), .link_rx_data(rxd),
    .link_rx_ready(rxr), .link_tx_valid(txv), .link_tx_data(txd),
    .link_tx_ready(txr), .mem_req(req), .mem_we(we), .mem_cfg(cfg),
    .mem_addr(ma), .mem_be(be), .mem_wdata(wd), .mem_rdata(rd),
    .mem_ack(ack), .refresh_req(rfr), .core_rate_mhz_x10(mhz),
    .core_rate_invalid(inval), .seq_busy(busy), .boot_start(bst),
    .boot_from_rom(brom), .boot_low_pri(lowp), .boot_link(blink),
    .boot_iptr(iptr), .boot_wptr(wptr));
  rlb_mem_model i_rlb_mem_model (.clock(clock), .rstn(rstn),
    .mem_req(req), .mem_we(we), .mem_cfg(cfg), .mem_addr(ma),
    .mem_be(be), .mem_wdata(wd), .mem_rdata(rd), .mem_ack(ack));
  initial forever #2.5 clock = ~clock;
  //////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check
  // hold the byte until ready is sampled high, then scramble the lane
  task automatic send(int l, logic [7:0] b);
    int n;
    @(posedge clock);
    rxv[l] <= 1'b1;
    rxd[8*l+:8] <= b;
    n = 0;
    @(posedge clock);
    while (rxr[l] !== 1'b1 && n < 3000) begin
      n++;
      @(posedge clock);
    end
    if (n == 3000) check("rx ready", 1, 0);
    rxv[l] <= 1'b0;
    rxd[8*l+:8] <= ~b;
  endtask : send
  task automatic send_word(int l, logic [31:0] w);
    for (int i = 0; i < 4; i++) send(l, w[8*i+:8]);
  endtask : send_word
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  //////////////////////////////////////////////////////////////////////////
  // output watcher: reply bytes are matched against the oldest note
  always @(posedge clock) begin
    txr <= reset_pin ? 4'h0 : 4'($random(seed));
    if (rfr === 1'b1) n_ref++;
    if (req && ack && cfg) n_cfg++;
    for (int i = 0; i < 4; i++) if (txv[i] && txr[i]) begin
      if (exp_q.size() == 0) check("tx byte", 0, 1);
      else check("tx byte", exp_q.pop_front(), txd[8*i+:8]);
    end
  end
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      straps <= 3'(c);
      repeat (5) @(posedge clock);
      check("rate", tab[c], mhz);
      check("invalid", (c == 5 || c == 7), inval);
      check("tx in reset", 0, txd | txv);
    end
    $display("test rate and reset done");
    // reset stays high a further eight reference periods after the rate checks
    repeat (8 * REF_PERIOD_NS / CLK_PERIOD_NS) @(posedge clock);
    reset_pin <= 1'b0; // clock has run from time zero, lead scaled
    repeat (4) @(posedge clock);
    check("rx ready", 4'hf, rxr);
    check("busy", 1, busy);
    adr = 32'h80000100;
    dat = $random(seed);
    send(2, CTRL_POKE);
    send_word(2, adr);
    send_word(2, dat);
    for (int i = 0; i < 4; i++) exp_q.push_back(dat[8*i+:8]);
    send(1, CTRL_PEEK);
    send_word(1, adr);
    for (int n = 0; n < 500 && exp_q.size() > 0; n++) @(posedge clock);
    check("reply left", 0, exp_q.size());
    check("poke word", dat, i_rlb_mem_model.mem[adr]);
    check("cfg reads", 36, n_cfg);
    check("refresh", 8, n_ref);
    $display("test sequence and peek poke done");
    dat = $random(seed);
    send(0, 8'h04);
    send_word(0, dat);
    for (int n = 0; n < 500 && bst !== 1'b1; n++) @(posedge clock);
    check("boot iptr", USER_MEMORY_BASE, iptr);
    check("boot link", 0, blink);
    check("low pri", 1, lowp);
    check("load word", dat, i_rlb_mem_model.mem[USER_MEMORY_BASE]);
    check("boot start", 1, bst);
    check("boot wptr", USER_MEMORY_BASE + 32'h4, wptr);
    check("from rom", 0, brom);
    check("busy", 0, busy);
    $display("test link boot done");
    // second reset: scanned config found, refresh off, boot from ROM
    reset_pin <= 1'b1; // links idle, no other memory master
    scan_a <= 1'b1;
    rom_sel <= 1'b1;
    repeat (8 * REF_PERIOD_NS / CLK_PERIOD_NS) @(posedge clock);
    check("tx in reset", 0, txd | txv);
    check("low pri reset", 0, lowp);
    reset_pin <= 1'b0;
    for (int n = 0; n < 1000 && bst !== 1'b1; n++) @(posedge clock);
    check("boot start", 1, bst);
    check("rom iptr", ROM_BOOT_ADDR, iptr);
    check("rom wptr", USER_MEMORY_BASE, wptr);
    check("from rom", 1, brom);
    check("low pri", 1, lowp);
    check("refresh off", 8, n_ref);
    check("cfg reads", 72, n_cfg);
    rom_sel <= 1'b0;
    repeat (8) @(posedge clock);
    check("rom kept", 1, brom);
    $display("test rom boot done");
    stop_test();
  end
endmodule : rlb_boot_ctrl_test
